// [shared/csa_pkg.sv]
package csa_pkg;
    // Word layout: 24 data bits in four 6-bit characters, parity above
    localparam int DATA_W    = 24;
    localparam int CHAR_W    = 6;
    localparam int NCHAR     = 4;
    localparam int WORD_W    = 28;
    localparam int PAR_LSB   = 24;
    // Address layout
    localparam int ADDR_W    = 18;
    localparam int WADDR_W   = 15;
    localparam int STATE_W   = 3;
    localparam int GSEL_LSB  = 14;
    localparam int GSEL_W    = 4;
    localparam int NGROUP    = 2;
    localparam int BANK_AW   = 13;
    localparam int BANK_SEL  = 0;
    localparam int WORD_LSB  = 1;
    localparam int CHAR1_IDX = 2;
    localparam int MAX_CH    = 4;
    // Timing
    localparam int CLK_NS     = 4;
    localparam int CYCLE_NS   = 900;
    localparam int ACCESS_NS  = 600;
    localparam int CYCLE_CYC  = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_CYC = ACCESS_NS / CLK_NS;
    // Protection
    localparam logic [WADDR_W-1:0] LOADER_LO = 15'h7FE0;
    localparam int LIMIT_W = 6;
    localparam int PAGE_SH = 9;
    localparam logic [PAGE_SH-1:0] PAGE_ZERO = 9'h000;
    localparam logic [STATE_W-1:0] STATE_ZERO = 3'h0;

    typedef enum logic [2:0] {
        H_IDLE = 3'h1,
        H_REQ  = 3'h2,
        H_WAIT = 3'h4
    } csa_hstate_t;

    // Odd parity bit for each character of a data word
    function automatic logic [NCHAR-1:0] csa_char_par(
        input logic [DATA_W-1:0] d
    );
        logic [NCHAR-1:0] p;
        p = '0;
        for (int i = 0; i < NCHAR; i++) begin
            p[i] = ~^d[i*CHAR_W +: CHAR_W];
        end
        return p;
    endfunction
endpackage

// [shared/csa_chan_if.sv]
`timescale 1ns/1ns
interface csa_chan_if import csa_pkg::*; ;
    logic              req;
    logic              wr;
    logic              amode;
    logic              apar;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
    logic              ack;
    logic              done;
    logic              aperr;
    logic [WORD_W-1:0] rdata;

    modport dev (
        input  req, wr, amode, apar, addr, wdata,
        output ack, done, aperr, rdata
    );
    modport host (
        output req, wr, amode, apar, addr, wdata,
        input  ack, done, aperr, rdata
    );
endinterface // csa_chan_if

// [hdl/csa_bank.sv]
`timescale 1ns/1ns
module csa_bank import csa_pkg::*; #(
    parameter int AW  = BANK_AW,
    parameter int CYC = CYCLE_CYC,
    parameter int ACC = ACCESS_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    input  wire logic              start,
    input  wire logic              wr,
    input  wire logic [AW-1:0]     addr,
    input  wire logic [WORD_W-1:0] wdata,
    output logic                   busy,
    output logic                   done,
    output logic [WORD_W-1:0]      rdata
);
    localparam int CW = $clog2(CYC + 1);
    localparam logic [CW-1:0] CNT_ONE = CW'(1);
    localparam logic [CW-1:0] CNT_CYC = CW'(CYC);
    localparam logic [CW-1:0] CNT_ACC = CW'(ACC);

    logic [WORD_W-1:0] mem [2**AW];
    logic [CW-1:0]     cnt_r;
    logic [CW-1:0]     cnt_nxt;
    logic [WORD_W-1:0] rdata_r;
    wire               take = ce & start & ~busy;

    // Cycle counter: busy for a whole storage cycle, answer at access time
    assign busy    = cnt_r != '0;
    assign done    = ce & (cnt_r == CNT_ACC);
    assign rdata   = rdata_r;
    assign cnt_nxt = take ? CNT_ONE :
                     (cnt_r == CNT_CYC) ? '0 :
                     busy ? cnt_r + CNT_ONE : cnt_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r   <= '0;
            rdata_r <= '0;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
            if (take) begin
                rdata_r <= mem[addr]; // Old word returned on write too
            end
        end
    end

    // Array has no reset; contents are unknown until written
    always_ff @(posedge clk) begin
        if (take && wr) begin
            mem[addr] <= wdata;
        end
    end
endmodule // csa_bank

// [hdl/csa_store.sv]
`timescale 1ns/1ns
// What this block does
// RULE1 - Words hold 24 data and 4 parity
// RULE2 - One odd parity bit per character
// RULE3 - Four 8K banks in two 16K groups
// RULE4 - Up to four channels reach either group
// RULE5 - Group scanner grants one word, then advances
// RULE6 - Two banks of a group overlap references
// RULE7 - Group answers when switches match bits 14-17
// RULE8 - Separate group switches per channel per group
// RULE9 - Normal mode requester zeroes upper address bits
// RULE10 - Supervisor mode prepends state bits to address
// RULE11 - Even and odd words in different banks
// RULE12 - All parity is odd
// RULE13 - Requester ignores parity errors unless enabled
// RULE14 - Address parity sent, regenerated, error returned
// RULE15 - Bad address parity turns write into read
// RULE16 - Requester sends character parity, stored unchanged
// RULE17 - Address mode write regenerates character 1 parity
// RULE18 - Read returns parity; requester checks it
// RULE19 - Normal mode protected write reads, flags status
// RULE20 - Supervisor protected write reads, exemptions, unrecorded
// RULE21 - Interrupt sequence writes never protected
// RULE22 - Loader area protected unless loader entry; code protects it in normal mode only
// RULE23 - Two switch-sized areas in 512-word steps
// RULE24 - Scanner order is circular with wrap
module csa_store import csa_pkg::*; #(
    parameter int CH_NUM = MAX_CH,
    parameter int CYC    = CYCLE_CYC,
    parameter int ACC    = ACCESS_CYC
) (
    input  wire logic                                   REF_CLK,
    input  wire logic                                   RSTN,
    input  wire logic                                   CE,
    input  wire logic [CH_NUM-1:0]                      CH_FITTED,
    input  wire logic [CH_NUM-1:0][NGROUP-1:0][GSEL_W-1:0] GROUP_SWITCH,
    csa_chan_if.dev                                     CH [CH_NUM]
);
    localparam int CIW   = (CH_NUM > 1) ? $clog2(CH_NUM) : 1;
    localparam int NBANK = 2 * NGROUP;
    localparam logic [CIW-1:0] CH_LAST = CIW'(CH_NUM - 1);
    localparam logic [CIW-1:0] CH_ONE  = CIW'(1);

    // Bank number from group and the even/odd address bit
    function automatic int bank_of(input int g, input logic b);
        return 2 * g + int'(b);
    endfunction

    // First candidate at or after the pointer, circularly
    function automatic logic [CIW:0] rr_pick(
        input logic [CH_NUM-1:0] cand,
        input logic [CIW-1:0]    ptr
    );
        logic [CIW:0] res;
        int           idx;
        res = '0;
        for (int i = CH_NUM - 1; i >= 0; i--) begin
            idx = (int'(ptr) + i) % CH_NUM;
            if (cand[idx]) begin
                res = {1'b1, CIW'(idx)};
            end
        end
        return res;
    endfunction

    // Switch straps, synchronised
    logic [CH_NUM-1:0]                      fit_m_r;
    logic [CH_NUM-1:0]                      fit_s_r;
    logic [CH_NUM-1:0][NGROUP-1:0][GSEL_W-1:0] gsw_m_r;
    logic [CH_NUM-1:0][NGROUP-1:0][GSEL_W-1:0] gsw_s_r;

    // Channel side
    logic [CH_NUM-1:0]              req;
    logic [CH_NUM-1:0]              wr_ok;
    logic [CH_NUM-1:0]              apar_ok;
    logic [CH_NUM-1:0]              bsel;
    logic [CH_NUM-1:0][NGROUP-1:0]  gmatch;
    logic [ADDR_W-1:0]              addr [CH_NUM];
    logic [WORD_W-1:0]              wdat [CH_NUM];
    logic [CH_NUM-1:0]              ack;
    logic [CH_NUM-1:0]              fin;
    logic [CH_NUM-1:0]              fpe;
    logic [WORD_W-1:0]              frd [CH_NUM];
    logic [CH_NUM-1:0]              done_r;
    logic [CH_NUM-1:0]              aperr_r;
    logic [WORD_W-1:0]              rdat_r [CH_NUM];

    // Scanner side
    logic [NGROUP-1:0][CH_NUM-1:0]  cand;
    logic [NGROUP-1:0]              gv;
    logic [CIW-1:0]                 gc [NGROUP];
    logic [CIW-1:0]                 ptr_r [NGROUP];

    // Bank side
    logic [NBANK-1:0]               bstart;
    logic [NBANK-1:0]               bbusy;
    logic [NBANK-1:0]               bdone;
    logic [WORD_W-1:0]              brd [NBANK];
    logic [CIW-1:0]                 owner_r [NBANK];
    logic [NBANK-1:0]               bpe_r;

    // Straps come from panel switches, so they cross in two stages
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            fit_m_r <= '0;
            fit_s_r <= '0;
            gsw_m_r <= '0;
            gsw_s_r <= '0;
        end else if (CE) begin
            fit_m_r <= CH_FITTED;
            fit_s_r <= fit_m_r;
            gsw_m_r <= GROUP_SWITCH;
            gsw_s_r <= gsw_m_r;
        end
    end

    // Per-channel decode of address, parity and write data
    for (genvar c = 0; c < CH_NUM; c++) begin : g_ch
        logic [NCHAR-1:0] cpar;
        logic [WORD_W-1:0] wd;
        assign req[c]     = CH[c].req;
        assign addr[c]    = CH[c].addr;
        assign apar_ok[c] = ^{CH[c].addr, CH[c].apar}; // RULE12 RULE14
        assign wr_ok[c]   = CH[c].wr & apar_ok[c]; // RULE15
        assign bsel[c]    = CH[c].addr[BANK_SEL]; // RULE11
        assign cpar       = csa_char_par(CH[c].wdata[DATA_W-1:0]);
        // Address mode write rebuilds only the character 1 parity
        always_comb begin
            wd = CH[c].wdata; // RULE1 RULE16
            if (CH[c].amode && CH[c].wr) begin
                wd[PAR_LSB + CHAR1_IDX] = cpar[CHAR1_IDX]; // RULE17 RULE2
            end
        end
        assign wdat[c] = wd;
        for (genvar g = 0; g < NGROUP; g++) begin : g_grp
            assign gmatch[c][g] = gsw_s_r[c][g] ==
                CH[c].addr[GSEL_LSB +: GSEL_W]; // RULE7 RULE8
        end
        assign CH[c].ack   = ack[c];
        assign CH[c].done  = done_r[c];
        assign CH[c].aperr = aperr_r[c];
        assign CH[c].rdata = rdat_r[c]; // RULE18
    end

    // Candidates per group: fitted, requesting, switch match, bank free.
    // A channel matching both groups (bad strapping) goes to group 0.
    always_comb begin
        for (int g = 0; g < NGROUP; g++) begin
            for (int c = 0; c < CH_NUM; c++) begin
                cand[g][c] = req[c] & fit_s_r[c] & gmatch[c][g] // RULE4
                    & (g == 0 || !gmatch[c][0])
                    & ~bbusy[bank_of(g, bsel[c])]; // RULE6
            end
        end
    end

    // One scanner per group
    for (genvar g = 0; g < NGROUP; g++) begin : g_scan
        logic [CIW:0] pick;
        assign pick  = rr_pick(cand[g], ptr_r[g]); // RULE5
        assign gv[g] = CE & pick[CIW];
        assign gc[g] = pick[CIW-1:0];
        // Pointer moves past the granted channel at grant time
        always_ff @(posedge REF_CLK or negedge RSTN) begin
            if (!RSTN) begin
                ptr_r[g] <= '0;
            end else if (gv[g]) begin
                ptr_r[g] <= (gc[g] == CH_LAST) ? '0 : gc[g] + CH_ONE; // RULE24
            end
        end
        for (genvar b = 0; b < 2; b++) begin : g_bank
            localparam int K = 2 * g + b;
            assign bstart[K] = gv[g] & (bsel[gc[g]] == 1'(b)); // RULE3
            csa_bank #(
                .AW  (BANK_AW),
                .CYC (CYC),
                .ACC (ACC)
            ) u_bank (
                .clk   (REF_CLK),
                .rst_n (RSTN),
                .ce    (CE),
                .start (bstart[K]),
                .wr    (wr_ok[gc[g]]),
                .addr  (addr[gc[g]][WORD_LSB +: BANK_AW]),
                .wdata (wdat[gc[g]]),
                .busy  (bbusy[K]),
                .done  (bdone[K]),
                .rdata (brd[K])
            );
            // Remember who owns the cycle and its address parity verdict
            always_ff @(posedge REF_CLK or negedge RSTN) begin
                if (!RSTN) begin
                    owner_r[K] <= '0;
                    bpe_r[K]   <= 1'b0;
                end else if (bstart[K]) begin
                    owner_r[K] <= gc[g];
                    bpe_r[K]   <= ~apar_ok[gc[g]]; // RULE14
                end
            end
        end
    end

    // Grant strobe back to the channel
    always_comb begin
        ack = '0;
        for (int g = 0; g < NGROUP; g++) begin
            if (gv[g]) begin
                ack[gc[g]] = 1'b1;
            end
        end
    end

    // Route bank answers to owners; one answer per channel at a time
    always_comb begin
        for (int c = 0; c < CH_NUM; c++) begin
            fin[c] = 1'b0;
            fpe[c] = 1'b0;
            frd[c] = '0;
            for (int k = 0; k < NBANK; k++) begin
                if (bdone[k] && owner_r[k] == CIW'(c)) begin
                    fin[c] = 1'b1;
                    fpe[c] = bpe_r[k];
                    frd[c] = brd[k];
                end
            end
        end
    end

    // Answer registers keep the data lines glitch-free
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            done_r  <= '0;
            aperr_r <= '0;
            for (int c = 0; c < CH_NUM; c++) begin
                rdat_r[c] <= '0;
            end
        end else if (CE) begin
            done_r  <= fin;
            aperr_r <= fin & fpe;
            for (int c = 0; c < CH_NUM; c++) begin
                if (fin[c]) begin
                    rdat_r[c] <= frd[c];
                end
            end
        end
    end
endmodule // csa_store

// [hdl/csa_req.sv]
`timescale 1ns/1ns
module csa_req import csa_pkg::*; (
    input  wire logic               REF_CLK,
    input  wire logic               RSTN,
    input  wire logic               CE,
    csa_chan_if.host                CH,
    input  wire logic               START,
    input  wire logic               WRITE,
    input  wire logic               ADDR_MODE,
    input  wire logic               SUPERVISOR,
    input  wire logic               USE_OPERAND,
    input  wire logic [STATE_W-1:0] INSTR_STATE,
    input  wire logic [STATE_W-1:0] OPER_STATE,
    input  wire logic [WADDR_W-1:0] WORD_ADDR,
    input  wire logic [DATA_W-1:0]  WDATA,
    input  wire logic               MONITOR_STATE,
    input  wire logic               BLOCK_CTRL,
    input  wire logic               INTR_SEQ,
    input  wire logic               CLEAR_ILLEGAL,
    input  wire logic               PARITY_STOP,
    input  wire logic               PARITY_INT,
    input  wire logic               LOADER_ENTRY,
    input  wire logic [LIMIT_W-1:0] LOWER_LIMIT,
    input  wire logic [LIMIT_W-1:0] UPPER_LIMIT,
    output logic                    BUSY,
    output logic                    DONE,
    output logic [DATA_W-1:0]       RDATA,
    output logic                    PARITY_ERR,
    output logic                    ILLEGAL_WRITE
);
    localparam int SW_W = 3 + 2 * LIMIT_W;

    csa_hstate_t       st_r;
    csa_hstate_t       st_nxt;
    logic [SW_W-1:0]   sw_m_r;
    logic [SW_W-1:0]   sw_s_r;
    logic [ADDR_W-1:0] addr_r;
    logic [WORD_W-1:0] wdata_r;
    logic              wr_r;
    logic              amode_r;
    logic              done_r;
    logic              perr_r;
    logic              ill_r;
    logic [DATA_W-1:0] rdata_r;

    // Synchronised panel switches
    wire               par_en = sw_s_r[0] | sw_s_r[1];
    wire               ldr_en = sw_s_r[2];
    wire [LIMIT_W-1:0] lo_lim = sw_s_r[3 +: LIMIT_W];
    wire [LIMIT_W-1:0] hi_lim = sw_s_r[3 + LIMIT_W +: LIMIT_W];

    // Address forming and protection decode
    wire [STATE_W-1:0] sbits = USE_OPERAND ? OPER_STATE : INSTR_STATE;
    wire [ADDR_W-1:0]  addr  = SUPERVISOR ? {sbits, WORD_ADDR} // RULE10
                                          : {STATE_ZERO, WORD_ADDR}; // RULE9
    wire in_ldr  = ~SUPERVISOR & (WORD_ADDR >= LOADER_LO) & ~ldr_en; // RULE22
    wire in_lo   = WORD_ADDR < {lo_lim, PAGE_ZERO}; // RULE23
    wire in_hi   = ~WORD_ADDR < {hi_lim, PAGE_ZERO}; // RULE23
    wire exempt  = INTR_SEQ // RULE21
                 | (SUPERVISOR & (MONITOR_STATE | BLOCK_CTRL)); // RULE20
    wire blocked = WRITE & (in_ldr | in_lo | in_hi) & ~exempt; // RULE19
    wire take    = CE & START & (st_r == H_IDLE);
    wire finish  = CE & CH.done & (st_r == H_WAIT);
    wire dbad    = csa_char_par(CH.rdata[DATA_W-1:0])
                   != CH.rdata[PAR_LSB +: NCHAR]; // RULE18 RULE12
    wire perr    = CH.aperr | (~wr_r & dbad);

    assign CH.req     = st_r == H_REQ;
    assign CH.wr      = wr_r;
    assign CH.amode   = amode_r;
    assign CH.addr    = addr_r;
    assign CH.apar    = ~^addr_r; // RULE14
    assign CH.wdata   = wdata_r;
    assign BUSY       = st_r != H_IDLE;
    assign DONE       = done_r;
    assign RDATA      = rdata_r;
    assign PARITY_ERR = perr_r;
    assign ILLEGAL_WRITE = ill_r;

    // Request sequence: hold request until granted, then await answer
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            H_IDLE:  if (take) st_nxt = H_REQ;
            H_REQ:   if (CH.ack) st_nxt = H_WAIT;
            H_WAIT:  if (CH.done) st_nxt = H_IDLE;
            default: st_nxt = H_IDLE;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            st_r   <= H_IDLE;
            sw_m_r <= '0;
            sw_s_r <= '0;
        end else if (CE) begin
            st_r   <= st_nxt;
            sw_m_r <= {UPPER_LIMIT, LOWER_LIMIT, LOADER_ENTRY,
                       PARITY_INT, PARITY_STOP};
            sw_s_r <= sw_m_r;
        end
    end

    // Latch the request; a blocked write goes out as a read
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            addr_r  <= '0;
            wdata_r <= '0;
            wr_r    <= 1'b0;
            amode_r <= 1'b0;
        end else if (take) begin
            addr_r  <= addr;
            wr_r    <= WRITE & ~blocked; // RULE19 RULE20
            amode_r <= ADDR_MODE;
            wdata_r <= {csa_char_par(WDATA), WDATA}; // RULE16
        end
    end

    // Answer side; set of the illegal flag wins over its clear
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            done_r  <= 1'b0;
            perr_r  <= 1'b0;
            ill_r   <= 1'b0;
            rdata_r <= '0;
        end else if (CE) begin
            done_r <= finish;
            perr_r <= finish & perr & par_en; // RULE13
            if (finish) begin
                rdata_r <= CH.rdata[DATA_W-1:0];
            end
            if (take && blocked && !SUPERVISOR) begin
                ill_r <= 1'b1; // RULE19
            end else if (CLEAR_ILLEGAL) begin
                ill_r <= 1'b0;
            end
        end
    end
endmodule // csa_req

// [verif/csa_chan_props.sv]
`timescale 1ns/1ns
module csa_chan_props import csa_pkg::*; #(
    parameter int ACC = ACCESS_CYC
) (
    input wire logic              REF_CLK,
    input wire logic              RSTN,
    input wire logic              req,
    input wire logic              wr,
    input wire logic              amode,
    input wire logic              apar,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [WORD_W-1:0] wdata,
    input wire logic              ack,
    input wire logic              done,
    input wire logic              aperr,
    input wire logic [WORD_W-1:0] rdata
);
    localparam int DLY = ACC + 1;
    // Expected odd parity per character, worked out apart from the design
    wire logic [3:0] wpar = {~^wdata[23:18], ~^wdata[17:12],
                             ~^wdata[11:6], ~^wdata[5:0]};
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    // A grant with sound address parity, then a clean completion
    sequence s_good_grant;
        ack && (^{addr, apar});
    endsequence
    sequence s_clean_done;
        done && !aperr;
    endsequence
    AST_ACK_NEEDS_REQ: assert property (ack |-> req)
        else $error("grant without request");
    AST_GRANT_TO_DONE: assert property (s_good_grant |-> ##DLY s_clean_done)
        else $error("completion late or flagged");
    AST_ACK_DROPS_REQ: assert property (ack |=> !req)
        else $error("request held past grant");
    AST_REQ_HOLDS: assert property
        (req && !ack |=> req && $stable(addr) && $stable(wr))
        else $error("request changed while waiting");
    AST_APAR_ODD: assert property (req |-> ^{addr, apar})
        else $error("address parity not odd");
    AST_WDATA_PAR: assert property (req && wr && !amode |-> wdata[27:24] == wpar)
        else $error("character parity wrong");
    AST_APERR_WITH_DONE: assert property (aperr |-> done)
        else $error("parity error without completion");
    AST_DONE_NOT_ACK: assert property (done |-> !ack)
        else $error("second reference while one open");
    AST_RDATA_HOLDS: assert property (!done |-> $stable(rdata))
        else $error("read data moved without completion");
endmodule // csa_chan_props

// [verif/core_storage_access_control_tb_top.sv]
`timescale 1ns/1ns
module core_storage_access_control_tb_top import csa_pkg::*; ;
    localparam int ACC_T = 4;
    localparam logic [23:0] D1 = 24'hA5C3F1;
    localparam logic [23:0] D2 = 24'h3C0F96;
    logic               clk, start = 0, wr = 0, sup = 0, mon = 0, le = 0;
    logic               rst_n = 0, ce = 1, clr = 0, pst = 1, pin = 0, am = 0;
    logic               blk = 0, intr = 0, uop = 0;
    logic [2:0]         ist = '0, ost = '0;
    logic [1:0]         fit = 2'h3;
    logic [15:0]        sw = 16'h5010;
    logic [WADDR_W-1:0] wa = '0;
    logic [DATA_W-1:0]  wd = '0, rd;
    logic [LIMIT_W-1:0] lo = '0, up = '0;
    logic               busy, done, perr, illw, g1, e1;
    logic [WORD_W-1:0]  r1;
    int                 miscompares = 0, check_count = 0, cyc = 0;
    csa_chan_if ch_if [2] ();
    csa_store #(.CH_NUM(2), .CYC(8), .ACC(ACC_T)) csa_store_i (
        .REF_CLK(clk), .RSTN(rst_n), .CE(ce), .CH_FITTED(fit),
        .GROUP_SWITCH(sw), .CH(ch_if));
    csa_req csa_req_i (
        .REF_CLK(clk), .RSTN(rst_n), .CE(ce), .CH(ch_if[0]), .START(start),
        .WRITE(wr), .ADDR_MODE(am), .SUPERVISOR(sup), .USE_OPERAND(uop),
        .INSTR_STATE(ist), .OPER_STATE(ost), .WORD_ADDR(wa), .WDATA(wd),
        .MONITOR_STATE(mon), .BLOCK_CTRL(blk), .INTR_SEQ(intr),
        .CLEAR_ILLEGAL(clr), .PARITY_STOP(pst), .PARITY_INT(pin),
        .LOADER_ENTRY(le), .LOWER_LIMIT(lo), .UPPER_LIMIT(up), .BUSY(busy),
        .DONE(done), .RDATA(rd), .PARITY_ERR(perr), .ILLEGAL_WRITE(illw));
    csa_chan_props #(.ACC(ACC_T)) csa_chan_props_i (
        .REF_CLK(clk), .RSTN(rst_n), .req(ch_if[0].req), .wr(ch_if[0].wr),
        .amode(ch_if[0].amode), .apar(ch_if[0].apar), .addr(ch_if[0].addr),
        .wdata(ch_if[0].wdata), .ack(ch_if[0].ack), .done(ch_if[0].done),
        .aperr(ch_if[0].aperr), .rdata(ch_if[0].rdata));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) cyc <= cyc + 1;
    function automatic logic [3:0] opar(input logic [23:0] d);
        return {~^d[23:18], ~^d[17:12], ~^d[11:6], ~^d[5:0]};
    endfunction
    task automatic chk(input logic [WORD_W-1:0] got, exp);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Host reference through the requester; bounded wait on DONE
    task automatic hop(input logic w, input logic [14:0] a,
                       input logic [23:0] d);
        int n;
        @(negedge clk);
        start = 1'b1;
        wr = w;
        wa = a;
        wd = d;
        @(negedge clk);
        start = 1'b0;
        for (n = 0; n < 40 && done !== 1'b1; n++) @(negedge clk);
        chk(n < 40, 1'b1);
    endtask
    // Second channel driven by hand so address parity can be broken
    task automatic cop(input logic w, a_m, bad, input logic [17:0] a,
                       input logic [27:0] d);
        int n;
        @(negedge clk);
        ch_if[1].req = 1'b1;
        ch_if[1].wr = w;
        ch_if[1].amode = a_m;
        ch_if[1].addr = a;
        ch_if[1].wdata = d;
        ch_if[1].apar = ~^a ^ bad;
        g1 = 1'b0;
        for (n = 0; n < 30 && !g1; n++) begin
            @(posedge clk);
            g1 = (ch_if[1].ack === 1'b1);
        end
        @(negedge clk);
        ch_if[1].req = 1'b0;
        ch_if[1].addr = ~a; // Released lines must not keep old value
        ch_if[1].wdata = ~d;
        if (g1) begin
            for (n = 0; n < 30 && ch_if[1].done !== 1'b1; n++) @(negedge clk);
            chk(n < 30, 1'b1);
            r1 = ch_if[1].rdata;
            e1 = ch_if[1].aperr;
        end
    endtask
    task automatic t_rw();
        hop(1'b1, 15'h0012, D1);
        hop(1'b0, 15'h0012, 24'h0);
        chk(rd, D1);
        chk(perr, 1'b0);
        chk(ch_if[0].rdata[27:24], opar(D1));
        cop(1'b0, 1'b0, 1'b0, 18'h00012, 28'h0);
        chk(r1, {opar(D1), D1});
        $display("t_rw finished");
    endtask
    task automatic t_amode();
        for (int m = 0; m < 2; m++) begin
            cop(1'b1, m[0], 1'b0, 18'h00020, {opar(D2) ^ 4'h5, D2});
            cop(1'b0, 1'b0, 1'b0, 18'h00020, 28'h0);
            chk(r1, {opar(D2) ^ (m ? 4'h1 : 4'h5), D2});
        end
        cop(1'b1, 1'b0, 1'b1, 18'h00020, {opar(D1), D1});
        chk(e1, 1'b1);
        cop(1'b0, 1'b0, 1'b0, 18'h00020, 28'h0);
        chk(e1, 1'b0);
        chk(r1, {opar(D2) ^ 4'h1, D2});
        // Stored word has a bad character 3 parity; only the switches report it
        {pst, pin} = 2'h1;
        hop(1'b0, 15'h0020, 24'h0);
        chk(perr, 1'b1);
        pin = 1'b0;
        hop(1'b0, 15'h0020, 24'h0);
        chk(perr, 1'b0);
        $display("t_amode finished");
    endtask
    task automatic t_group();
        int n;
        hop(1'b1, 15'h4020, D1);
        cop(1'b0, 1'b0, 1'b0, 18'h14020, 28'h0);
        chk(g1, 1'b1);
        chk(r1, {opar(D1), D1});
        cop(1'b0, 1'b0, 1'b0, 18'h04020, 28'h0);
        chk(g1, 1'b0);
        n = cyc;
        fork
            hop(1'b0, 15'h0012, D1);
            cop(1'b0, 1'b0, 1'b0, 18'h00013, 28'h0);
        join
        chk(cyc - n < 12, 1'b1);
        $display("t_group finished");
    endtask
    task automatic t_prot();
        // Panel switches need two edges to cross before the request
        le = 1'b1;
        @(negedge clk);
        hop(1'b1, 15'h7FE4, D1);
        chk(illw, 1'b0);
        le = 1'b0;
        @(negedge clk);
        hop(1'b1, 15'h7FE4, D2);
        chk(illw, 1'b1);
        hop(1'b0, 15'h7FE4, 24'h0);
        chk(rd, D1);
        clr = 1'b1;
        @(negedge clk);
        clr = 1'b0;
        chk(illw, 1'b0);
        sup = 1'b1;
        lo = 6'h01;
        repeat (3) @(negedge clk);
        hop(1'b1, 15'h0012, D2);
        hop(1'b0, 15'h0012, 24'h0);
        chk({illw, rd}, {1'b0, D1});
        mon = 1'b1;
        hop(1'b1, 15'h0012, D2);
        hop(1'b0, 15'h0012, 24'h0);
        chk(rd, D2);
        {mon, blk} = 2'h1;
        hop(1'b1, 15'h0012, D1);
        hop(1'b0, 15'h0012, 24'h0);
        chk(rd, D1);
        {sup, blk, intr} = 3'h1;
        hop(1'b1, 15'h0012, D2);
        hop(1'b0, 15'h0012, 24'h0);
        chk({illw, rd}, {1'b0, D2});
        // Group 0 no longer answers 0; only the state bits reach group 1
        sw = 16'h502F;
        {sup, intr, ist} = {2'h2, 3'h1};
        hop(1'b1, 15'h0412, D1);
        {uop, ost, ist} = {1'b1, 3'h1, 3'h0};
        hop(1'b0, 15'h0412, 24'h0);
        chk(rd, D1);
        $display("t_prot finished");
    endtask
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Watchdog sized well above the few hundred cycles the tests need
    initial begin
        repeat (4000) @(posedge clk);
        miscompares++;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        complete_run();
    end
    initial begin
        ch_if[1].req = 1'b0;
        ch_if[1].wr = 1'b0;
        ch_if[1].amode = 1'b0;
        ch_if[1].apar = 1'b1;
        ch_if[1].addr = '0;
        ch_if[1].wdata = '0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        t_rw();
        t_amode();
        t_group();
        t_prot();
        complete_run();
    end
endmodule // core_storage_access_control_tb_top
